// [bench/switch_contacts.sv]
`timescale 1ns/1ps
module switch_contacts (
    input  wire logic [3:0] high_side_output,
    input  wire logic [2:0] closed,
    input  wire logic [2:0] fed,
    output logic      [2:0] wake_input
);
    // A fed contact sees battery only while its switch supply is on, else the pull-down wins
    assign wake_input[0] = closed[0] & (~fed[0] | high_side_output[0]);
    assign wake_input[1] = closed[1] & (~fed[1] | high_side_output[0]);
    assign wake_input[2] = closed[2] & (~fed[2] | high_side_output[1]);
endmodule

// [bench/tb_cyclic_sense_wake_timers.sv]
`timescale 1ns/1ps
module tb_cyclic_sense_wake_timers;
    import cyclic_timer_pkg::*;
    localparam int TL = 4;
    logic        ref_clk, arst_n, soft_reset, reg_wr, reg_rd, restart_clear_hs;
    logic        first_timer_wake_enable, second_timer_wake_enable;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [11:0] high_side_config;
    logic [2:0]  wake_input, wake_level, wake_input_event, closed, fed;
    logic [3:0]  high_side_output;
    logic [1:0]  timer_wake_event;
    int          err_total, n_compared, k, hi, per, ev;
    int          on_t [5] = '{1, 3, 10, 100, 200};
    int          per_t [4] = '{100, 200, 500, 1000};

    cyclic_sense_wake_timers #(.TICK_LEN(TL), .SHORT_LEN(4), .LONG_LEN(8)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .restart_clear_hs(restart_clear_hs),
        .high_side_config(high_side_config), .first_timer_wake_enable(first_timer_wake_enable),
        .second_timer_wake_enable(second_timer_wake_enable), .wake_input(wake_input),
        .high_side_output(high_side_output), .wake_level(wake_level), .wake_input_event(wake_input_event),
        .timer_wake_event(timer_wake_event));
    switch_contacts contacts (.high_side_output(high_side_output), .closed(closed), .fed(fed),
        .wake_input(wake_input));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk("reg_rdata", 16'(reg_rdata), 16'(exp));
    endtask

    // Counts cycles until the switch output reaches the wanted level
    task automatic wait_lvl(input int i, input logic lvl, output int n);
        n = 0;
        while (high_side_output[i] !== lvl && n < 9000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // Skips the first cycle after a restart so the figures are tick aligned
    task automatic meas(input int i, output int h, output int p);
        int n;
        wait_lvl(i, 1'b1, n);
        wait_lvl(i, 1'b0, n);
        wait_lvl(i, 1'b1, n);
        wait_lvl(i, 1'b0, h);
        wait_lvl(i, 1'b1, n);
        p = h + n;
    endtask

    task automatic count_ev(input int i, input int n, output int e);
        e = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (timer_wake_event[i] === 1'b1) e++;
        end
    endtask

    task automatic hold(input int i, input int w, input logic exp, input int nev);
        int e;
        e = 0;
        closed[i] = 1'b1;
        repeat (w) begin
            @(negedge ref_clk);
            if (wake_input_event[i] === 1'b1) e++;
        end
        chk("wake_level", 16'(wake_level[i]), 16'(exp));
        closed[i] = 1'b0;
        repeat (14) begin
            @(negedge ref_clk);
            if (wake_input_event[i] === 1'b1) e++;
        end
        chk("wake_level", 16'(wake_level[i]), 16'h0000);
        chk("wake_input_event", 16'(e), 16'(nev));
    endtask

    initial begin
        repeat (90000) @(posedge ref_clk);
        err_total++;
        summarize();
    end

    initial begin
        {arst_n, soft_reset, reg_wr, reg_rd, restart_clear_hs} = 5'h00;
        {first_timer_wake_enable, second_timer_wake_enable, closed, fed} = 8'h00;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        high_side_config = 12'h000;
        err_total = 0;
        n_compared = 0;
        repeat (6) @(negedge ref_clk);
        arst_n = 1'b1;
        rd(ADDR_WAKE_FILTER, 8'h00);
        rd(ADDR_FIRST_TIMER, 8'h00);
        rd(ADDR_SECOND_TIMER, 8'h00);
        wr(ADDR_WAKE_FILTER, 8'hff);
        wr(ADDR_FIRST_TIMER, 8'hff);
        wr(ADDR_SECOND_TIMER, 8'hff);
        rd(ADDR_WAKE_FILTER, 8'h3f);
        rd(ADDR_FIRST_TIMER, 8'h77);
        rd(ADDR_SECOND_TIMER, 8'h77);
        rd(7'h0a, 8'h00);
        @(negedge ref_clk);
        soft_reset = 1'b1;
        @(negedge ref_clk);
        soft_reset = 1'b0;
        rd(ADDR_WAKE_FILTER, 8'h00);
        rd(ADDR_FIRST_TIMER, 8'h00);
        rd(ADDR_SECOND_TIMER, 8'h00);
        high_side_config = 12'h05a;
        wr(ADDR_FIRST_TIMER, 8'h60);
        wr(ADDR_SECOND_TIMER, 8'h60);
        repeat (4) @(negedge ref_clk);
        chk("high_side_output", 16'(high_side_output), 16'h0007);
        wr(ADDR_FIRST_TIMER, 8'h00);
        wr(ADDR_SECOND_TIMER, 8'h70);
        repeat (4) @(negedge ref_clk);
        chk("high_side_output", 16'(high_side_output), 16'h0004);
        for (k = 0; k < 5; k++) begin
            wr(ADDR_FIRST_TIMER, 8'((k + 1) * 16 + 2));
            meas(0, hi, per);
            chk("on_time", 16'(hi), 16'(on_t[k] * TL));
        end
        for (k = 0; k < 4; k++) begin
            wr(ADDR_FIRST_TIMER, 8'(16 + k));
            meas(0, hi, per);
            chk("period", 16'(per), 16'(per_t[k] * TL));
        end
        wr(ADDR_SECOND_TIMER, 8'h11);
        meas(1, hi, per);
        chk("second_period", 16'(per), 16'(per_t[1] * TL));
        first_timer_wake_enable = 1'b1;
        wr(ADDR_FIRST_TIMER, 8'h10);
        count_ev(0, 1000, ev);
        chk("timer_wake_event", 16'(ev), 16'h0003);
        first_timer_wake_enable = 1'b0;
        wr(ADDR_FIRST_TIMER, 8'h10);
        count_ev(0, 1000, ev);
        chk("timer_wake_event", 16'(ev), 16'h0000);
        wr(ADDR_FIRST_TIMER, 8'h00);
        wr(ADDR_SECOND_TIMER, 8'h00);
        wr(ADDR_WAKE_FILTER, 8'h00);
        hold(0, 3, 1'b0, 0);
        hold(0, 10, 1'b1, 2);
        wr(ADDR_WAKE_FILTER, 8'h01);
        hold(0, 6, 1'b0, 0);
        hold(0, 14, 1'b1, 2);
        fed = 3'b110;
        closed = 3'b110;
        wr(ADDR_WAKE_FILTER, 8'h38);
        repeat (40) @(negedge ref_clk);
        chk("wake_level", 16'(wake_level), 16'h0000);
        first_timer_wake_enable = 1'b1;
        second_timer_wake_enable = 1'b1;
        wr(ADDR_FIRST_TIMER, 8'h20);
        repeat (30) @(negedge ref_clk);
        chk("wake_level", 16'(wake_level), 16'h0002);
        wr(ADDR_SECOND_TIMER, 8'h20);
        count_ev(1, 30, ev);
        chk("timer_wake_event", 16'(ev), 16'h0001);
        chk("wake_level", 16'(wake_level), 16'h0006);
        closed[1] = 1'b0;
        repeat (30) @(negedge ref_clk);
        chk("wake_level", 16'(wake_level), 16'h0006);
        repeat (400) @(negedge ref_clk);
        chk("wake_level", 16'(wake_level), 16'h0004);
        wr(ADDR_WAKE_FILTER, 8'h08);
        @(negedge ref_clk);
        restart_clear_hs = 1'b1;
        @(negedge ref_clk);
        restart_clear_hs = 1'b0;
        rd(ADDR_FIRST_TIMER, 8'h00);
        rd(ADDR_SECOND_TIMER, 8'h20);
        summarize();
    end
endmodule

// [rtl/cycle_timer.sv]
`timescale 1ns/1ps
module cycle_timer
    import cyclic_timer_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic [2:0] on_code,
    input  wire logic [2:0] per_code,
    output logic            timer_out,
    output logic            on_end,
    output logic            period_start
);
    timer_state_t state_ff;
    logic         restart_ff;
    logic [15:0]  cnt_ff;
    logic [15:0]  nxt_cnt;
    logic         stop_code;

    assign nxt_cnt   = cnt_ff + 16'h0001;
    assign stop_code = (on_code == ON_STOP_LOW) || (on_code == ON_STOP_HIGH) || (on_code == ON_RESERVED);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= STOP_LOW;
            restart_ff   <= 1'b0;
            cnt_ff       <= 16'h0000;
            timer_out    <= 1'b0;
            on_end       <= 1'b0;
            period_start <= 1'b0;
        end else begin
            // Restart one cycle after the write so the new on-time code decides it,
            // a write that stops the timer must not pulse the output first
            restart_ff   <= restart;
            on_end       <= 1'b0;
            period_start <= 1'b0;
            if (stop_code) begin
                state_ff  <= (on_code == ON_STOP_HIGH) ? STOP_HIGH : STOP_LOW;
                timer_out <= (on_code == ON_STOP_HIGH);
                cnt_ff    <= 16'h0000;
            end else if (restart_ff || state_ff == STOP_LOW || state_ff == STOP_HIGH) begin
                state_ff     <= RUN_ON;
                timer_out    <= 1'b1;
                cnt_ff       <= 16'h0000;
                period_start <= 1'b1;
            end else if (tick) begin
                if (nxt_cnt >= PERIOD_TICKS[per_code]) begin
                    state_ff     <= RUN_ON;
                    timer_out    <= 1'b1;
                    cnt_ff       <= 16'h0000;
                    period_start <= 1'b1;
                end else begin
                    cnt_ff <= nxt_cnt;
                    if (state_ff == RUN_ON && nxt_cnt >= ON_TICKS[on_code]) begin
                        state_ff  <= RUN_OFF;
                        timer_out <= 1'b0;
                        on_end    <= 1'b1;
                    end
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_stop_low_out: assert property (on_code == ON_STOP_LOW |=> !timer_out)
        else $error("stopped-low timer drives high");
    a_stop_high_out: assert property (on_code == ON_STOP_HIGH |=> timer_out && !on_end)
        else $error("stopped-high timer not high");
    a_start_high: assert property (restart_ff && !stop_code |=> timer_out && period_start)
        else $error("timer did not start on write");
    a_on_end_low: assert property (on_end |-> !timer_out && $past(timer_out))
        else $error("on-time end not a falling edge");
endmodule

// [rtl/cyclic_sense_wake_timers.sv]
`timescale 1ns/1ps
module cyclic_sense_wake_timers
    import cyclic_timer_pkg::*;
#(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int SHORT_LEN = FILT_SHORT_CYCLES,
    parameter int LONG_LEN  = FILT_LONG_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        soft_reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        restart_clear_hs,
    input  wire logic [11:0] high_side_config,
    input  wire logic        first_timer_wake_enable,
    input  wire logic        second_timer_wake_enable,
    input  wire logic [2:0]  wake_input,
    output logic      [3:0]  high_side_output,
    output logic      [2:0]  wake_level,
    output logic      [2:0]  wake_input_event,
    output logic      [1:0]  timer_wake_event
);
    // Tick counter is 13 bits wide, input stability counters 12 bits
    if (TICK_LEN < 1 || TICK_LEN > 8192 || SHORT_LEN < 1 || LONG_LEN < SHORT_LEN || LONG_LEN > 4095) begin : g_bad_timing
        $error("unsupported timing parameters");
    end

    logic [7:0]  wake_filter_select_ff;
    logic [7:0]  first_timer_config_ff;
    logic [7:0]  second_timer_config_ff;
    logic [12:0] tick_cnt_ff;
    logic        tick_ff;
    logic [1:0]  timer_out;
    logic [1:0]  timer_on_end;
    logic [1:0]  timer_start;
    logic [1:0]  restart_wr;
    logic [1:0]  cyclic_use;

    assign restart_wr[0] = reg_wr && reg_addr == ADDR_FIRST_TIMER;
    assign restart_wr[1] = reg_wr && reg_addr == ADDR_SECOND_TIMER;
    // A timer is in cyclic use when any wake input samples at its on-time end
    assign cyclic_use[0] = wake_filter_select_ff[1:0] == 2'h2 || wake_filter_select_ff[3:2] == 2'h2
                        || wake_filter_select_ff[5:4] == 2'h2;
    assign cyclic_use[1] = wake_filter_select_ff[1:0] == 2'h3 || wake_filter_select_ff[3:2] == 2'h3
                        || wake_filter_select_ff[5:4] == 2'h3;

    // Register writes; the restart clear takes priority over a write in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_filter_select_ff  <= FILTER_RESET;
            first_timer_config_ff  <= TIMER_RESET;
            second_timer_config_ff <= TIMER_RESET;
        end else if (soft_reset) begin
            wake_filter_select_ff  <= FILTER_RESET;
            first_timer_config_ff  <= TIMER_RESET;
            second_timer_config_ff <= TIMER_RESET;
        end else begin
            if (reg_wr && reg_addr == ADDR_WAKE_FILTER) begin
                wake_filter_select_ff <= reg_wdata & FILTER_WR_MASK;
            end
            if (restart_clear_hs && cyclic_use[0]) begin
                first_timer_config_ff <= TIMER_RESET;
            end else if (restart_wr[0]) begin
                first_timer_config_ff <= reg_wdata & TIMER_WR_MASK;
            end
            if (restart_clear_hs && cyclic_use[1]) begin
                second_timer_config_ff <= TIMER_RESET;
            end else if (restart_wr[1]) begin
                second_timer_config_ff <= reg_wdata & TIMER_WR_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_WAKE_FILTER) begin
                reg_rdata <= wake_filter_select_ff;
            end else if (reg_addr == ADDR_FIRST_TIMER) begin
                reg_rdata <= first_timer_config_ff;
            end else if (reg_addr == ADDR_SECOND_TIMER) begin
                reg_rdata <= second_timer_config_ff;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Shared 0.1 ms time base
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_ff <= 13'h0000;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff == 13'(TICK_LEN - 1)) begin
            tick_cnt_ff <= 13'h0000;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 13'h0001;
            tick_ff     <= 1'b0;
        end
    end

    cycle_timer first_cycle_timer (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .tick         (tick_ff),
        .restart      (restart_wr[0]),
        .on_code      (first_timer_config_ff[ON_LSB +: 3]),
        .per_code     (first_timer_config_ff[PER_LSB +: 3]),
        .timer_out    (timer_out[0]),
        .on_end       (timer_on_end[0]),
        .period_start (timer_start[0])
    );

    cycle_timer second_cycle_timer (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .tick         (tick_ff),
        .restart      (restart_wr[1]),
        .on_code      (second_timer_config_ff[ON_LSB +: 3]),
        .per_code     (second_timer_config_ff[PER_LSB +: 3]),
        .timer_out    (timer_out[1]),
        .on_end       (timer_on_end[1]),
        .period_start (timer_start[1])
    );

    // Switch supply and cyclic wake, independent of sensing
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            high_side_output <= 4'h0;
            timer_wake_event <= 2'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                case (high_side_config[3*i +: 3])
                    HS_CFG_ON:     high_side_output[i] <= 1'b1;
                    HS_CFG_FIRST:  high_side_output[i] <= timer_out[0];
                    HS_CFG_SECOND: high_side_output[i] <= timer_out[1];
                    default:       high_side_output[i] <= 1'b0;
                endcase
            end
            timer_wake_event[0] <= timer_start[0] && first_timer_wake_enable;
            timer_wake_event[1] <= timer_start[1] && second_timer_wake_enable;
        end
    end

    for (genvar k = 0; k < 3; k++) begin : g_wake
        logic [1:0]  sel;
        logic [11:0] stable_cnt_ff;
        logic        raw_prev_ff;
        logic        qualified;
        assign sel = wake_filter_select_ff[2*k +: 2];
        always_comb begin
            if (sel[1]) begin
                qualified = (sel[0] ? timer_on_end[1] : timer_on_end[0])
                         && stable_cnt_ff >= 12'(SHORT_LEN);
            end else if (sel == FLT_STATIC_LONG) begin
                qualified = stable_cnt_ff >= 12'(LONG_LEN);
            end else begin
                qualified = stable_cnt_ff >= 12'(SHORT_LEN);
            end
        end
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                raw_prev_ff   <= 1'b0;
                stable_cnt_ff <= 12'h000;
                wake_level[k] <= 1'b0;
                wake_input_event[k] <= 1'b0;
            end else begin
                raw_prev_ff <= wake_input[k];
                if (wake_input[k] != raw_prev_ff) begin
                    stable_cnt_ff <= 12'h000;
                end else if (stable_cnt_ff < 12'(LONG_LEN)) begin
                    stable_cnt_ff <= stable_cnt_ff + 12'h001;
                end
                wake_input_event[k] <= qualified && raw_prev_ff != wake_level[k];
                if (qualified) begin
                    wake_level[k] <= raw_prev_ff;
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_filter_read;
        reg_rd && reg_addr == ADDR_WAKE_FILTER;
    endsequence
    sequence s_timer_read;
        reg_rd && (reg_addr == ADDR_FIRST_TIMER || reg_addr == ADDR_SECOND_TIMER);
    endsequence

    a_filter_reserved_zero: assert property (s_filter_read |=> reg_rdata[7:6] == 2'h0)
        else $error("filter reserved bits read nonzero");
    a_timer_reserved_zero: assert property (s_timer_read |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("timer reserved bits read nonzero");
    a_soft_reset_clears: assert property (soft_reset |=> first_timer_config_ff == 8'h00
        && second_timer_config_ff == 8'h00 && wake_filter_select_ff == 8'h00)
        else $error("soft reset left a register set");
    a_restart_clear: assert property (restart_clear_hs && cyclic_use[0] |=> first_timer_config_ff == 8'h00)
        else $error("cyclic timer not cleared on restart");
    a_hs_follows_first: assert property (high_side_config[2:0] == HS_CFG_FIRST
        && $stable(high_side_config) |=> high_side_output[0] == $past(timer_out[0]))
        else $error("switch does not follow first timer");
    a_wake_gated: assert property (!first_timer_wake_enable |=> !timer_wake_event[0])
        else $error("disabled timer produced wake");
    a_wake_on_expiry: assert property (timer_start[1] && second_timer_wake_enable |=> timer_wake_event[1])
        else $error("enabled timer expiry lost");
    a_cyclic_only_at_end: assert property (wake_filter_select_ff[1:0] == 2'h2 && !timer_on_end[0]
        |=> !wake_input_event[0])
        else $error("cyclic input changed outside sampling instant");
    a_static_short_qual: assert property (wake_filter_select_ff[1:0] == 2'h0 && wake_input_event[0]
        |-> $past(g_wake[0].stable_cnt_ff >= 12'(SHORT_LEN)))
        else $error("static event without stable input");
endmodule

// [rtl/cyclic_timer_pkg.sv]
// How it works
// - Unused bits of the filter and timer registers read zero and ignore writes.
// - Three two-bit filter selectors: input three 5:4, two 3:2, one 1:0.
// - Selector 00: continuous static sensing with a 16 us filter.
// - Selector 01: continuous static sensing with a 64 us filter.
// - Selector 10: cyclic sensing, 16 us filter at end of first timer on-time.
// - Selector 11: cyclic sensing, 16 us filter at end of second timer on-time.
// - On-time 000 stops the timer low, 110 stops it high.
// - On-time codes 001..101 give 0.1, 0.3, 1, 10, 20 ms; 111 reserved.
// - Period codes 000..110 give 10, 20, 50, 100, 200 ms, 1 s, 2 s.
// - Second timer is a separate identical instance, on-time 6:4, period 2:0.
// - Writing a running on-time starts the timer, no separate start command.
// - Restart clearing of switches with cyclic sensing also clears that timer's fields.
// - Cyclic sensing and cyclic wake run together without suppressing each other.
// - Power-on or soft reset sets all three registers to zero.
// - Timer expiry gives a wake event only while its wake-enable bit is set.
// - Switch config 010 follows the first timer, 011 the second timer.
package cyclic_timer_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int TICK_TIME_US  = 100;
    localparam int FILT_SHORT_US = 16;
    localparam int FILT_LONG_US  = 64;
    localparam int TICK_CYCLES       = (TICK_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILT_SHORT_CYCLES = (FILT_SHORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FILT_LONG_CYCLES  = (FILT_LONG_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam logic [6:0] ADDR_WAKE_FILTER  = 7'h09;
    localparam logic [6:0] ADDR_FIRST_TIMER  = 7'h0c;
    localparam logic [6:0] ADDR_SECOND_TIMER = 7'h0d;
    localparam logic [7:0] FILTER_WR_MASK    = 8'h3f;
    localparam logic [7:0] TIMER_WR_MASK     = 8'h77;
    localparam logic [7:0] FILTER_RESET      = 8'h00;
    localparam logic [7:0] TIMER_RESET       = 8'h00;
    localparam int         ON_LSB            = 4;
    localparam int         PER_LSB           = 0;

    localparam logic [2:0] ON_STOP_LOW  = 3'h0;
    localparam logic [2:0] ON_STOP_HIGH = 3'h6;
    localparam logic [2:0] ON_RESERVED  = 3'h7;
    localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
    localparam logic [2:0] HS_CFG_ON     = 3'h1;
    localparam logic [2:0] HS_CFG_FIRST  = 3'h2;
    localparam logic [2:0] HS_CFG_SECOND = 3'h3;

    // Durations in 0.1 ms ticks, indexed by code; reserved codes fall back to safe values
    localparam logic [7:0][15:0] ON_TICKS = {16'h0000, 16'h0000, 16'h00c8, 16'h0064,
                                             16'h000a, 16'h0003, 16'h0001, 16'h0000};
    localparam logic [7:0][15:0] PERIOD_TICKS = {16'h0064, 16'h4e20, 16'h2710, 16'h07d0,
                                                 16'h03e8, 16'h01f4, 16'h00c8, 16'h0064};

    typedef enum logic [1:0] {
        STOP_LOW  = 2'b00,
        RUN_ON    = 2'b01,
        RUN_OFF   = 2'b11,
        STOP_HIGH = 2'b10
    } timer_state_t;
endpackage
